/* File: verilog/apt_pkg.sv */
package apt_pkg;
	// ----------------------------------------
	// Register map (indices on the plain port)
	// ----------------------------------------
	localparam logic [3:0] ADDR_PHASE_LOW = 4'h0;
	localparam logic [3:0] ADDR_PHASE_HIGH = 4'h1;
	localparam logic [3:0] ADDR_RES_LOW = 4'h2;
	localparam logic [3:0] ADDR_RES_HIGH = 4'h3;
	localparam logic [3:0] ADDR_PER_LOW = 4'h4;
	localparam logic [3:0] ADDR_PER_HIGH = 4'h5;
	localparam logic [3:0] ADDR_CTRL = 4'h6;
	localparam logic [3:0] ADDR_FLAGS = 4'h7;
	// ----------------------------------------
	// Field positions and widths
	// ----------------------------------------
	localparam int CNT_W = 16;
	localparam int PHS_W = 10;
	localparam int CTRL_MODE_BIT = 0;
	localparam int FLAG_PHASE_BIT = 0;
	localparam int FLAG_PERIOD_BIT = 1;
	localparam int FLAG_MISS_BIT = 2;
	// ----------------------------------------
	// Reset values and thresholds
	// ----------------------------------------
	localparam logic [15:0] RES_RESET = 16'h0000;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] MISS_MARGIN = 16'h0002;
endpackage

/* File: verilog/apt_divider.sv */
`timescale 1ns/10ps
module apt_divider (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic tick_i,
	input wire logic restart_i,
	input wire logic [15:0] limit_i,
	// Output
	output logic pulse_o
);
	logic [15:0] count;
	logic [15:0] next_count;

	// Counts 0..limit, so the ratio is limit plus one
	always_comb begin
		next_count = count;
		pulse_o = 1'b0;
		if (restart_i) begin
			next_count = 16'h0000;
		end else if (tick_i) begin
			if (count >= limit_i) begin
				next_count = 16'h0000;
				pulse_o = 1'b1;
			end else begin
				next_count = count + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= 16'h0000;
		end else begin
			count <= next_count;
		end
	end
endmodule // apt_divider

/* File: verilog/apt_core.sv */
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
// Overview of operation
// - Clock over resolution plus one increments the period counter.
// - Single-pulse mode latches the period counter on each input pulse.
// - Clock divided by latched period plus one advances the phase counter.
// - Each phase pulse drives phase clock out and sets phase event flag.
// - Phase counter starts at zero; single mode final value is resolution.
// - Single mode: phase counter returns to zero on next input pulse.
// - Multi mode: clear period on every pulse, latch it except after a miss.
// - First pulse after a miss: period pulse, period flag, phase clear.
// - High phase register shows bits nine and eight, upper six zero.
// - Low phase register shows eight low phase bits, zero at reset.
module apt_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Input signal
	input wire logic sig_i,
	// Register port
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Event outputs
	output logic phase_clock_out_o,
	output logic period_clock_out_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [0:0] {
		APT_ARMED = 1'b0,
		APT_MISSED = 1'b1
	} apt_miss_t;

	logic [15:0] resolution_setting;
	logic [15:0] next_resolution_setting;
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [15:0] period_cnt;
	logic [15:0] next_period_cnt;
	logic [15:0] period_latch;
	logic [15:0] next_period_latch;
	logic [9:0] phase_count;
	logic [9:0] next_phase_count;
	logic [2:0] flags;
	logic [2:0] next_flags;
	logic [7:0] next_rdata;
	logic sig_q;
	logic period_clk_q;
	logic next_period_clk;
	apt_miss_t miss_st;
	apt_miss_t next_miss_st;
	logic sig_rise;
	logic per_tick;
	logic phs_tick;
	logic multi_mode;
	logic miss_now;
	logic restart_per;
	logic [16:0] miss_limit;

	assign sig_rise = sig_i & ~sig_q;
	assign multi_mode = ctrl[apt_pkg::CTRL_MODE_BIT];
	assign miss_limit = {1'b0, period_latch} + {1'b0, apt_pkg::MISS_MARGIN};
	assign miss_now = multi_mode && (miss_st == APT_ARMED) &&
		({1'b0, period_cnt} > miss_limit);
	assign restart_per = sig_rise &&
		!(multi_mode && miss_st == APT_MISSED);

	// ----------------------------------------
	// Dividers
	// ----------------------------------------
	apt_divider u_res_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(1'b1),
		.restart_i(1'b0),
		.limit_i(resolution_setting),
		.pulse_o(per_tick)
	);

	apt_divider u_phs_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(1'b1),
		.restart_i(sig_rise),
		.limit_i(period_latch),
		.pulse_o(phs_tick)
	);

	assign phase_clock_out_o = phs_tick;
	assign period_clock_out_o = period_clk_q;

	// ----------------------------------------
	// Measurement and phase logic
	// ----------------------------------------
	always_comb begin
		next_period_cnt = period_cnt;
		next_period_latch = period_latch;
		next_phase_count = phase_count;
		next_miss_st = miss_st;
		next_period_clk = 1'b0;
		next_flags = flags;
		if (restart_per) begin
			// Latch then clear; count includes zero
			next_period_latch = period_cnt;
			next_period_cnt = 16'h0000;
		end else if (per_tick && period_cnt != 16'hFFFF) begin
			next_period_cnt = period_cnt + 16'h0001;
		end
		if (!multi_mode) begin
			next_miss_st = APT_ARMED;
			if (sig_rise) begin
				next_phase_count = 10'h000;
				next_period_clk = 1'b1;
			end else if (phs_tick &&
				{6'h00, phase_count} < resolution_setting) begin
				// Holds at the final value until the next pulse
				next_phase_count = phase_count + 10'h001;
			end
		end else begin
			if (miss_now) begin
				next_miss_st = APT_MISSED;
			end
			if (sig_rise && miss_st == APT_MISSED) begin
				next_miss_st = APT_ARMED;
				next_period_clk = 1'b1;
				next_phase_count = 10'h000;
				next_period_cnt = 16'h0000;
			end else if (phs_tick) begin
				next_phase_count = phase_count + 10'h001;
			end
		end
		// Hardware set wins over a software clear in the same cycle
		if (wr_i && addr_i == apt_pkg::ADDR_FLAGS) begin
			next_flags = flags & ~wdata_i[2:0];
		end
		if (phs_tick) begin
			next_flags[apt_pkg::FLAG_PHASE_BIT] = 1'b1;
		end
		if (next_period_clk && multi_mode) begin
			next_flags[apt_pkg::FLAG_PERIOD_BIT] = 1'b1;
		end else if (next_period_clk) begin
			next_flags[apt_pkg::FLAG_PERIOD_BIT] = 1'b1;
		end
		if (miss_now) begin
			next_flags[apt_pkg::FLAG_MISS_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sig_q <= 1'b0;
			period_cnt <= 16'h0000;
			period_latch <= 16'h0000;
			phase_count <= 10'h000;
			miss_st <= APT_ARMED;
			period_clk_q <= 1'b0;
			flags <= 3'h0;
		end else begin
			sig_q <= sig_i;
			period_cnt <= next_period_cnt;
			period_latch <= next_period_latch;
			phase_count <= next_phase_count;
			miss_st <= next_miss_st;
			period_clk_q <= next_period_clk;
			flags <= next_flags;
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_comb begin
		next_resolution_setting = resolution_setting;
		next_ctrl = ctrl;
		next_rdata = 8'h00;
		if (wr_i) begin
			case (addr_i)
				apt_pkg::ADDR_RES_LOW: begin
					next_resolution_setting[7:0] = wdata_i;
				end
				apt_pkg::ADDR_RES_HIGH: begin
					next_resolution_setting[15:8] = wdata_i;
				end
				apt_pkg::ADDR_CTRL: begin
					next_ctrl = wdata_i;
				end
				default: begin
				end
			endcase
		end
		if (rd_i) begin
			case (addr_i)
				apt_pkg::ADDR_PHASE_LOW: next_rdata = phase_count[7:0];
				apt_pkg::ADDR_PHASE_HIGH: begin
					next_rdata = {6'h00, phase_count[9:8]};
				end
				apt_pkg::ADDR_RES_LOW: next_rdata = resolution_setting[7:0];
				apt_pkg::ADDR_RES_HIGH: next_rdata = resolution_setting[15:8];
				apt_pkg::ADDR_PER_LOW: next_rdata = period_latch[7:0];
				apt_pkg::ADDR_PER_HIGH: next_rdata = period_latch[15:8];
				apt_pkg::ADDR_CTRL: next_rdata = ctrl;
				apt_pkg::ADDR_FLAGS: next_rdata = {5'h00, flags};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			resolution_setting <= apt_pkg::RES_RESET;
			ctrl <= apt_pkg::CTRL_RESET;
			rdata_o <= 8'h00;
		end else begin
			resolution_setting <= next_resolution_setting;
			ctrl <= next_ctrl;
			rdata_o <= next_rdata;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_PHASE_FLAG: assert property (@(posedge clk_i)
		disable iff (rst_i)
		phs_tick |=> flags[apt_pkg::FLAG_PHASE_BIT])
		else $error("phase flag not set by phase pulse");
	AST_SINGLE_LATCH: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(sig_rise && !multi_mode) |=> period_latch == $past(period_cnt))
		else $error("period not latched on pulse");
	AST_SINGLE_WRAP: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(sig_rise && !multi_mode) |=> phase_count == 10'h000)
		else $error("phase not cleared on pulse");
	// A lowered resolution may leave the count above it; it must then hold
	AST_PHASE_MAX: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(!multi_mode && !sig_rise &&
		{6'h00, phase_count} >= resolution_setting) |=> $stable(phase_count))
		else $error("phase passed resolution");
	AST_PHASE_STEP: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(phs_tick && !sig_rise && multi_mode && miss_st == APT_ARMED)
		|=> phase_count == $past(phase_count) + 10'h001)
		else $error("phase did not advance");
	// A phase pulse restarts its divider, so two never come back to back unless the latched period is zero
	AST_PHS_SPACING: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(phs_tick && !sig_rise && period_latch != 16'h0000) |=> !phs_tick)
		else $error("phase pulses too close");
	AST_MISS_RECOVER: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(multi_mode && sig_rise && miss_st == APT_MISSED) |=>
		period_clk_q && phase_count == 10'h000 &&
		flags[apt_pkg::FLAG_PERIOD_BIT])
		else $error("missing pulse recovery wrong");
	AST_MULTI_LATCH: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(multi_mode && sig_rise && miss_st == APT_ARMED) |=>
		period_cnt == 16'h0000 && period_latch == $past(period_cnt))
		else $error("multi latch wrong");
	AST_NO_PER_CLK: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(multi_mode && sig_rise && miss_st == APT_ARMED) |=> !period_clk_q)
		else $error("period pulse on a regular pulse");
	AST_MISS_NO_LATCH: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(multi_mode && sig_rise && miss_st == APT_MISSED) |=>
		period_cnt == 16'h0000 && period_latch == $past(period_latch))
		else $error("pulse after a miss was latched");
	AST_MISS_DETECT: assert property (@(posedge clk_i)
		disable iff (rst_i)
		miss_now |=> flags[apt_pkg::FLAG_MISS_BIT] && miss_st == APT_MISSED)
		else $error("missing pulse not flagged");
	AST_HIGH_READ: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(rd_i && addr_i == apt_pkg::ADDR_PHASE_HIGH) |=>
		rdata_o == {6'h00, $past(phase_count[9:8])})
		else $error("high phase read wrong");
	AST_LOW_READ: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(rd_i && addr_i == apt_pkg::ADDR_PHASE_LOW) |=>
		rdata_o == $past(phase_count[7:0]))
		else $error("low phase read wrong");
	AST_PER_TICK: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(resolution_setting == 16'h0000 && $stable(resolution_setting))
		|-> per_tick)
		else $error("divider ratio wrong");
	AST_PER_SPACING: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(per_tick && resolution_setting != 16'h0000) |=>
		(!per_tick || resolution_setting == 16'h0000))
		else $error("period ticks too close");
	AST_PERIOD_COUNT: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(per_tick && !sig_rise && period_cnt != 16'hFFFF) |=>
		period_cnt == $past(period_cnt) + 16'h0001)
		else $error("period counter did not advance");
endmodule // apt_core

/* File: sim/apt_pulse_src.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Periodic pulse source with one-shot tooth skip
// ----------------------------------------
module apt_pulse_src (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic en_i,
	input wire logic skip_i,
	input wire logic [15:0] period_i,
	// Output
	output logic sig_o
);
	logic [15:0] cnt;
	logic skip_pend;
	// Pulses stay two cycles high so rising edges are well apart
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 16'h0000;
			sig_o <= 1'b0;
			skip_pend <= 1'b0;
		end else if (!en_i) begin
			cnt <= 16'h0000;
			sig_o <= 1'b0;
		end else if (cnt == period_i - 16'h0001) begin
			cnt <= 16'h0000;
			sig_o <= !skip_pend;
			skip_pend <= skip_i;
		end else begin
			cnt <= cnt + 16'h0001;
			if (cnt == 16'h0001) begin
				sig_o <= 1'b0;
			end
			if (skip_i) begin
				skip_pend <= 1'b1;
			end
		end
	end
endmodule // apt_pulse_src

/* File: sim/test_apt_core.sv */
`timescale 1ns/10ps
module test_apt_core;
	logic clk_i, rst_i, sig, en, skip, wr_i, rd_i, rd_seen;
	logic [3:0] addr_i;
	logic [7:0] wdata_i, rdata_o;
	logic phs_o, per_o;
	logic [15:0] exp_q[$];
	logic [15:0] e;
	logic [31:0] rs;
	int n_mismatch, tests_run, cyc, n_per, base, n_phs, base_phs;
	apt_pulse_src u_apt_pulse_src (.clk_i(clk_i), .rst_i(rst_i),
		.en_i(en), .skip_i(skip), .period_i(16'h0048), .sig_o(sig));
	apt_core u_apt_core (.clk_i(clk_i), .rst_i(rst_i), .sig_i(sig),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .phase_clock_out_o(phs_o),
		.period_clock_out_o(per_o));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// Expectation is stored as mask and value
	task automatic rd(input logic [3:0] a, input logic [7:0] m,
			input logic [7:0] v);
		exp_q.push_back({m, v});
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask
	task automatic tooth();
		@(posedge sig);
		@(posedge clk_i);
	endtask
	task automatic stop_test();
		$display("mismatches %0d compares %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Monitor and timeout
	// ----------------------------------------
	always @(posedge clk_i) begin
		rd_seen <= rd_i;
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	always @(negedge clk_i) begin
		if (per_o === 1'b1) begin
			n_per++;
		end
		if (phs_o === 1'b1) begin
			n_phs++;
		end
		if (rd_seen === 1'b1) begin
			e = exp_q.pop_front();
			check(e[7:0], rdata_o & e[15:8]);
		end else begin
			// Read data stand only in the cycle after a read
			check(8'h00, rdata_o);
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_i, en, skip, wr_i, rd_i} = 5'h10;
		addr_i = 4'h0;
		wdata_i = 8'h00;
		rs = 32'hbecf;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(apt_pkg::ADDR_CTRL, 8'hFF, apt_pkg::CTRL_RESET);
		rd(apt_pkg::ADDR_RES_LOW, 8'hFF, apt_pkg::RES_RESET[7:0]);
		rd(apt_pkg::ADDR_RES_HIGH, 8'hFF, apt_pkg::RES_RESET[15:8]);
		rd(4'hF, 8'hFF, 8'h00);
		rd(apt_pkg::ADDR_PHASE_HIGH, 8'hFC, 8'h00);
		for (int i = 0; i < 3; i++) begin
			rs = xs(rs);
			wr(apt_pkg::ADDR_RES_LOW, rs[7:0]);
			wr(apt_pkg::ADDR_RES_HIGH, rs[15:8]);
			rd(apt_pkg::ADDR_RES_LOW, 8'hFF, rs[7:0]);
			rd(apt_pkg::ADDR_RES_HIGH, 8'hFF, rs[15:8]);
		end
		// Three phase steps: resolution written equal to the step count
		wr(apt_pkg::ADDR_RES_HIGH, 8'h00);
		wr(apt_pkg::ADDR_RES_LOW, 8'h03);
		en <= 1'b1;
		repeat (4) tooth();
		base = n_per;
		base_phs = n_phs;
		tooth();
		// One period pulse and three phase steps per input period
		check(8'h01, 8'(n_per - base));
		check(8'h03, 8'(n_phs - base_phs));
		repeat (3) @(posedge clk_i);
		rd(apt_pkg::ADDR_PHASE_LOW, 8'hFF, 8'h00);
		rd(apt_pkg::ADDR_PER_LOW, 8'hFC, 8'h10);
		rd(apt_pkg::ADDR_PER_HIGH, 8'hFF, 8'h00);
		wr(apt_pkg::ADDR_FLAGS, 8'h07);
		rd(apt_pkg::ADDR_FLAGS, 8'h02, 8'h00);
		repeat (50) @(posedge clk_i);
		rd(apt_pkg::ADDR_PHASE_LOW, 8'hFF, 8'h03);
		rd(apt_pkg::ADDR_FLAGS, 8'h01, 8'h01);
		rd(apt_pkg::ADDR_PHASE_HIGH, 8'hFC, 8'h00);
		// Multi-pulse: no period pulse until a tooth is missing
		wr(apt_pkg::ADDR_CTRL, 8'h01);
		wr(apt_pkg::ADDR_FLAGS, 8'h07);
		tooth();
		base = n_per;
		repeat (3) tooth();
		check(8'h00, 8'(n_per - base));
		skip <= 1'b1;
		@(posedge clk_i);
		skip <= 1'b0;
		tooth();
		repeat (3) @(posedge clk_i);
		rd(apt_pkg::ADDR_PHASE_LOW, 8'hFF, 8'h00);
		rd(apt_pkg::ADDR_FLAGS, 8'h06, 8'h06);
		check(8'h01, 8'(n_per - base));
		repeat (3) @(posedge clk_i);
		stop_test();
	end
endmodule // test_apt_core
